// ### actc_pkg.sv
// Package of timing constants for the conversion timing control ends
package actc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Conversion time for eight channels: 555*8-35 ns
  localparam int CONV_TIME_NS = 4405;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNV_HIGH_MIN_NS = 40;
  localparam int CNV_HIGH_MAX_NS = 60;
  localparam int CNV_HIGH_CYCLES = (CNV_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNV_HIGH_MAX_CYCLES = CNV_HIGH_MAX_NS / CLK_PERIOD_NS;
  localparam int CNV_LOW_MIN_NS = 420;
  localparam int CNV_LOW_CYCLES = (CNV_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_WAIT_MS = 10;
  localparam int INIT_CYCLES = INIT_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int REFBUF_WAIT_MS = 200;
  localparam int REFBUF_CYCLES = REFBUF_WAIT_MS * 1000000 / CLK_PERIOD_NS;
  // Length of the global reset triggered by the second power-down edge
  localparam int GRST_CYCLES = 100;
  localparam int CNT_W = 32;
  typedef enum logic [1:0] {ACTC_INIT, ACTC_IDLE, ACTC_CONV} actc_dev_state_type;
  typedef enum logic [2:0] {ACTC_H_WAIT, ACTC_H_READY, ACTC_H_HIGH, ACTC_H_BUSY,
                            ACTC_H_LOW} actc_host_state_type;
endpackage

// ### actc_if.sv
// Interface joining the converter end and the host controller end
`timescale 1ns/1ps
`default_nettype none
interface actc_if;
  logic convert_start_in;
  logic power_down_in;
  logic busy;
  modport dev (input convert_start_in, input power_down_in, output busy);
  modport host (output convert_start_in, output power_down_in, input busy);
endinterface
`default_nettype wire

// ### actc_dev.sv
// Converter end: start-edge sampling, busy, power-on init and global reset
`timescale 1ns/1ps
`default_nettype none
module actc_dev #(
  parameter int INIT_CYCLES = actc_pkg::INIT_CYCLES,
  parameter int CONV_CYCLES = actc_pkg::CONV_CYCLES,
  parameter int GRST_CYCLES = actc_pkg::GRST_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // Link to host
  actc_if.dev LINK,
  // Status to user
  output logic SAMPLE_HOLD,
  output logic SAMPLE_STROBE,
  output logic CONV_DONE,
  output logic READY
);
  logic [2:0] cnv_sync_ff;
  logic [2:0] pd_sync_ff;
  logic cnv_rise;
  logic pd_rise;
  logic pd_armed_ff;
  logic grst_ff;
  logic [actc_pkg::CNT_W-1:0] cnt_ff;
  logic [actc_pkg::CNT_W-1:0] grst_cnt_ff;
  logic busy_ff;
  logic init_end;
  logic start_ok;
  logic conv_end;
  actc_pkg::actc_dev_state_type state_ff;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edge detect reads only the second and third stage
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnv_sync_ff <= 3'h0;
      pd_sync_ff <= 3'h0;
    end else if (CLK_EN) begin
      cnv_sync_ff <= {cnv_sync_ff[1:0], LINK.convert_start_in};
      pd_sync_ff <= {pd_sync_ff[1:0], LINK.power_down_in};
    end
  end
  assign cnv_rise = cnv_sync_ff[1] & ~cnv_sync_ff[2];
  assign pd_rise = pd_sync_ff[1] & ~pd_sync_ff[2];

  ////////////////////////////////////////////////////////////////////////
  // Global reset: second power-down edge with no conversion between
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pd_armed_ff <= 1'b0;
      grst_ff <= 1'b0;
      grst_cnt_ff <= '0;
    end else if (CLK_EN) begin
      if (grst_ff) begin
        pd_armed_ff <= 1'b0;
        if (grst_cnt_ff >= actc_pkg::CNT_W'(GRST_CYCLES - 1)) begin
          grst_ff <= 1'b0;
        end
        grst_cnt_ff <= grst_cnt_ff + 1'b1;
      end else if (pd_rise && pd_armed_ff) begin
        grst_ff <= 1'b1;
        grst_cnt_ff <= '0;
      end else if (pd_rise) begin
        pd_armed_ff <= 1'b1;
      end else if (start_ok) begin
        // Only a conversion that starts between the edges, or the global reset itself, disarms
        pd_armed_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer events, all masked while the global reset runs
  assign init_end = !grst_ff && (state_ff == actc_pkg::ACTC_INIT)
                    && (cnt_ff >= actc_pkg::CNT_W'(INIT_CYCLES - 1));
  // Start only from idle with power-down low; other edges are lost
  assign start_ok = !grst_ff && (state_ff == actc_pkg::ACTC_IDLE) && cnv_rise
                    && !pd_sync_ff[2];
  // Full count every time; only the global reset cuts it short
  assign conv_end = !grst_ff && (state_ff == actc_pkg::ACTC_CONV)
                    && (cnt_ff >= actc_pkg::CNT_W'(CONV_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////
  // State and shared cycle counter
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= actc_pkg::ACTC_INIT;
      cnt_ff <= '0;
    end else if (CLK_EN) begin
      if (grst_ff) begin
        // Reset halts any conversion at once and restarts the init wait
        state_ff <= actc_pkg::ACTC_INIT;
        cnt_ff <= '0;
      end else begin
        case (state_ff)
          actc_pkg::ACTC_INIT: begin
            if (init_end) begin
              state_ff <= actc_pkg::ACTC_IDLE;
              cnt_ff <= '0;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
          actc_pkg::ACTC_IDLE: begin
            if (start_ok) begin
              state_ff <= actc_pkg::ACTC_CONV;
              cnt_ff <= '0;
            end
          end
          actc_pkg::ACTC_CONV: begin
            // Start edges here fall through unseen
            if (conv_end) begin
              state_ff <= actc_pkg::ACTC_IDLE;
              cnt_ff <= '0;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
          default: begin
            state_ff <= actc_pkg::ACTC_INIT;
            cnt_ff <= '0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Busy pin: high from the sampling edge to the end of the count
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (grst_ff || state_ff == actc_pkg::ACTC_INIT) begin
        busy_ff <= 1'b0;
      end else if (start_ok) begin
        busy_ff <= 1'b1;
      end else if (conv_end) begin
        busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Track/hold: acquisition lasts from the end of the count to the next accepted start edge
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      SAMPLE_HOLD <= 1'b0;
    end else if (CLK_EN) begin
      if (grst_ff) begin
        SAMPLE_HOLD <= 1'b0;
      end else if (start_ok) begin
        SAMPLE_HOLD <= 1'b1;
      end else if (conv_end || state_ff == actc_pkg::ACTC_IDLE) begin
        SAMPLE_HOLD <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-cycle pulse at the sampling instant
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      SAMPLE_STROBE <= 1'b0;
    end else if (CLK_EN) begin
      SAMPLE_STROBE <= start_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-cycle pulse as busy falls; never after an abort
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      CONV_DONE <= 1'b0;
    end else if (CLK_EN) begin
      CONV_DONE <= conv_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Results are only trusted once the init wait has run out
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      READY <= 1'b0;
    end else if (CLK_EN) begin
      if (grst_ff) begin
        READY <= 1'b0;
      end else if (init_end) begin
        READY <= 1'b1;
      end
    end
  end
  assign LINK.busy = busy_ff;
endmodule
`default_nettype wire

// ### actc_host.sv
// Host end: drives start pulses and power-down, honours busy and waits
`timescale 1ns/1ps
`default_nettype none
module actc_host #(
  parameter int INIT_CYCLES = actc_pkg::INIT_CYCLES,
  parameter int REFBUF_CYCLES = actc_pkg::REFBUF_CYCLES,
  parameter bit LONG_PULSE = 1'b0
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // User requests
  input wire logic START_REQ,
  input wire logic PD_REQ,
  input wire logic INT_REFBUF,
  // Status to user
  output logic START_ACCEPT,
  output logic CONV_DONE,
  output logic CAN_START,
  // Link to converter
  actc_if.host LINK
);
  actc_pkg::actc_host_state_type state_ff;
  logic [actc_pkg::CNT_W-1:0] cnt_ff;
  logic [actc_pkg::CNT_W-1:0] wait_lim;
  logic [2:0] busy_sync_ff;
  logic cnv_ff;
  logic pd_ff;

  assign wait_lim = INT_REFBUF ? actc_pkg::CNT_W'(REFBUF_CYCLES - 1)
                               : actc_pkg::CNT_W'(INIT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Busy arrives from the other end: three flops before use
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_sync_ff <= 3'h0;
    end else if (CLK_EN) begin
      busy_sync_ff <= {busy_sync_ff[1:0], LINK.busy};
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pd_ff <= 1'b0;
    end else if (CLK_EN) begin
      pd_ff <= PD_REQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start pulse sequencer; clean single-flop edge on the start pin
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= actc_pkg::ACTC_H_WAIT;
      cnt_ff <= '0;
      cnv_ff <= 1'b0;
      START_ACCEPT <= 1'b0;
      CONV_DONE <= 1'b0;
      CAN_START <= 1'b0;
    end else if (CLK_EN) begin
      START_ACCEPT <= 1'b0;
      CONV_DONE <= 1'b0;
      if (pd_ff) begin
        // Powered down or resetting: restart the post-reset wait
        state_ff <= actc_pkg::ACTC_H_WAIT;
        cnt_ff <= '0;
        cnv_ff <= 1'b0;
        CAN_START <= 1'b0;
      end else begin
        case (state_ff)
          actc_pkg::ACTC_H_WAIT: begin
            if (cnt_ff >= wait_lim) begin
              state_ff <= actc_pkg::ACTC_H_READY;
              CAN_START <= 1'b1;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
          actc_pkg::ACTC_H_READY: begin
            if (START_REQ) begin
              cnv_ff <= 1'b1;
              START_ACCEPT <= 1'b1;
              CAN_START <= 1'b0;
              cnt_ff <= '0;
              state_ff <= actc_pkg::ACTC_H_HIGH;
            end
          end
          actc_pkg::ACTC_H_HIGH: begin
            // Short pulse drops inside the 40-60ns window
            if (!LONG_PULSE && cnt_ff >= actc_pkg::CNT_W'(actc_pkg::CNV_HIGH_CYCLES - 1)) begin
              cnv_ff <= 1'b0;
            end
            cnt_ff <= cnt_ff + 1'b1;
            if (busy_sync_ff[2]) begin
              state_ff <= actc_pkg::ACTC_H_BUSY;
            end
          end
          actc_pkg::ACTC_H_BUSY: begin
            if (!busy_sync_ff[2]) begin
              cnv_ff <= 1'b0;
              CONV_DONE <= 1'b1;
              cnt_ff <= '0;
              state_ff <= actc_pkg::ACTC_H_LOW;
            end
          end
          actc_pkg::ACTC_H_LOW: begin
            if (cnt_ff >= actc_pkg::CNT_W'(actc_pkg::CNV_LOW_CYCLES - 1)) begin
              state_ff <= actc_pkg::ACTC_H_READY;
              CAN_START <= 1'b1;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
          default: begin
            state_ff <= actc_pkg::ACTC_H_WAIT;
            cnt_ff <= '0;
          end
        endcase
      end
    end
  end
  assign LINK.convert_start_in = cnv_ff;
  assign LINK.power_down_in = pd_ff;
endmodule
`default_nettype wire

// ### actc_monitor.sv
// Checker of the start, power-down and busy wires between the two ends
`timescale 1ns/1ps
`default_nettype none
module actc_monitor #(
  parameter int INIT_CYCLES = 50,
  parameter int CONV_CYCLES = 20,
  parameter int GRST_CYCLES = 100
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Link wires
  input wire logic convert_start_in,
  input wire logic power_down_in,
  input wire logic busy
);
  logic [31:0] up_ff, pd_ff, bz_ff, hi_ff, lo_ff;
  logic [1:0] pdn_ff;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      up_ff <= '0;
      pd_ff <= '0;
      bz_ff <= '0;
      hi_ff <= '0;
      lo_ff <= 32'h0000ffff;
    end else begin
      up_ff <= (up_ff == 32'h0000ffff) ? up_ff : up_ff + 32'h1;
      pd_ff <= power_down_in ? '0 : (pd_ff == 32'h0000ffff) ? pd_ff : pd_ff + 32'h1;
      bz_ff <= busy ? bz_ff + 32'h1 : '0;
      hi_ff <= convert_start_in ? hi_ff + 32'h1 : '0;
      lo_ff <= convert_start_in ? '0 : lo_ff + 32'h1;
    end
  end
  // Power-down edges since the last conversion began
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      pdn_ff <= '0;
    end else if ($rose(busy)) begin
      pdn_ff <= '0;
    end else if ($rose(power_down_in) && pdn_ff != 2'h3) begin
      pdn_ff <= pdn_ff + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_start_gives_busy: assert property (up_ff > INIT_CYCLES
    && pd_ff > INIT_CYCLES + GRST_CYCLES && $rose(convert_start_in) && !busy |-> ##3 $rose(busy))
    else $error("busy did not follow start");
  chk_conv_full_length: assert property ($fell(busy) && pdn_ff < 2'h2
    |-> bz_ff == CONV_CYCLES) else $error("conversion length wrong");
  chk_busy_capped: assert property (busy |-> bz_ff < CONV_CYCLES)
    else $error("busy too long");
  chk_init_quiet: assert property (up_ff < INIT_CYCLES |-> !busy)
    else $error("busy during init");
  chk_grst_abort: assert property ($rose(power_down_in) && pdn_ff == 2'h1 && busy
    |-> ##[1:6] !busy) else $error("global reset kept conversion");
  chk_start_high_time: assert property ($fell(convert_start_in) |-> !busy
    || (hi_ff >= actc_pkg::CNV_HIGH_CYCLES && hi_ff <= actc_pkg::CNV_HIGH_MAX_CYCLES))
    else $error("start high time wrong");
  chk_start_low_time: assert property ($rose(convert_start_in)
    |-> lo_ff >= actc_pkg::CNV_LOW_CYCLES) else $error("start low time short");
  chk_start_waits: assert property ($rose(convert_start_in)
    |-> up_ff >= INIT_CYCLES && pd_ff >= INIT_CYCLES) else $error("start too early");
  cover property ($fell(busy) && bz_ff == CONV_CYCLES);
  cover property ($rose(power_down_in) && pdn_ff == 2'h1 && busy);
  cover property ($rose(convert_start_in) && pd_ff > INIT_CYCLES + GRST_CYCLES);
endmodule
`default_nettype wire

// ### tb.sv
// Testbench: both ends joined, plus a second converter end on a hand-driven link
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int INIT = 50;
  localparam int REFB = 80;
  localparam int CONV = 20;
  localparam int GRST = 100;
  typedef struct {logic refbuf; int wait_cyc;} actc_row_type;
  actc_row_type rows [2] = '{'{1'b0, INIT}, '{1'b1, REFB}};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic start_req = 1'b0;
  logic pd_req = 1'b0;
  logic int_refbuf = 1'b0;
  logic hold, strobe, dev_done, ready, accept, can_start;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int busy2_cnt = 0;
  actc_if link();
  actc_if link2();
  always #5 clock = ~clock;
  actc_dev #(.INIT_CYCLES(INIT), .CONV_CYCLES(CONV), .GRST_CYCLES(GRST)) actc_dev_inst (
    .CLOCK(clock), .RESET_N(reset_n), .CLK_EN(1'b1), .LINK(link), .SAMPLE_HOLD(hold),
    .SAMPLE_STROBE(strobe), .CONV_DONE(dev_done), .READY(ready));
  actc_dev #(.INIT_CYCLES(INIT), .CONV_CYCLES(CONV), .GRST_CYCLES(GRST)) actc_dev_inst2 (
    .CLOCK(clock), .RESET_N(reset_n), .CLK_EN(1'b1), .LINK(link2), .SAMPLE_HOLD(),
    .SAMPLE_STROBE(), .CONV_DONE(), .READY());
  actc_host #(.INIT_CYCLES(INIT), .REFBUF_CYCLES(REFB)) actc_host_inst (
    .CLOCK(clock), .RESET_N(reset_n), .CLK_EN(1'b1), .START_REQ(start_req), .PD_REQ(pd_req),
    .INT_REFBUF(int_refbuf), .START_ACCEPT(accept), .CONV_DONE(), .CAN_START(can_start),
    .LINK(link));
  actc_monitor #(.INIT_CYCLES(INIT), .CONV_CYCLES(CONV), .GRST_CYCLES(GRST)) actc_monitor_inst (
    .CLOCK(clock), .RESET_N(reset_n), .convert_start_in(link.convert_start_in),
    .power_down_in(link.power_down_in), .busy(link.busy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Requests one conversion through the host end, measures busy on the link
  task automatic run_conv(output int len, output int st, output int hd);
    int n;
    len = 0;
    st = 0;
    hd = 0;
    n = 0;
    start_req <= 1'b1;
    while (accept !== 1'b1 && n < 200) begin tick(1); #1; n++; end
    tick(1);
    start_req <= 1'b0;
    while (link.busy !== 1'b1 && n < 300) begin tick(1); #1; n++; end
    while (link.busy === 1'b1 && len < 1000) begin
      st += (strobe === 1'b1);
      hd += (hold === 1'b1);
      tick(1);
      #1;
      len++;
    end
    check("done_pulse", dev_done, 1);
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles <= cycles + 1;
    busy2_cnt <= busy2_cnt + (link2.busy === 1'b1);
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    int n, len, st, hd;
    link2.convert_start_in = 1'b0;
    link2.power_down_in = 1'b0;
    tick(5);
    reset_n <= 1'b1;
    link2.convert_start_in <= 1'b1;
    tick(4);
    link2.convert_start_in <= 1'b0;
    tick(10);
    #1;
    check("busy_in_init", link2.busy, 0);
    check("ready_in_init", ready, 0);
    foreach (rows[i]) begin
      tick(1);
      int_refbuf <= rows[i].refbuf;
      pd_req <= 1'b1;
      tick(2);
      pd_req <= 1'b0;
      n = 0;
      while (can_start !== 1'b1 && n < 400) begin tick(1); #1; n++; end
      check("wait_len", n >= rows[i].wait_cyc && n <= rows[i].wait_cyc + 8, 1);
      run_conv(len, st, hd);
      check("busy_len", len, CONV);
      check("strobes", st, 1);
      check("hold_len", hd, CONV);
    end
    // Global reset mid-conversion; second power-down kept high past the reset timer
    tick(50);
    start_req <= 1'b1;
    while (link.busy !== 1'b1 && n < 1000) begin tick(1); #1; n++; end
    tick(1);
    start_req <= 1'b0;
    pd_req <= 1'b1;
    tick(2);
    pd_req <= 1'b0;
    tick(3);
    pd_req <= 1'b1;
    tick(7);
    #1;
    check("grst_abort", link.busy, 0);
    check("grst_reinit", ready, 0);
    tick(GRST + 10);
    pd_req <= 1'b0;
    tick(INIT + 20);
    check("grst_ready", ready, 1);
    tick(GRST);
    run_conv(len, st, hd);
    check("busy_after_grst", len, CONV);
    // Second end: a start edge inside busy must not lengthen the conversion
    link2.convert_start_in <= 1'b1;
    tick(4);
    link2.convert_start_in <= 1'b0;
    tick(6);
    link2.convert_start_in <= 1'b1;
    tick(4);
    link2.convert_start_in <= 1'b0;
    tick(CONV + 20);
    check("busy_ignored_edge", busy2_cnt, CONV);
    give_verdict();
  end
endmodule
`default_nettype wire
